// ==== common/mci_defs.vh ====
`ifndef MCI_DEFS_VH
`define MCI_DEFS_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define MCI_OP_ROTATE_RIGHT 8'h01
`define MCI_OP_ROTATE_LEFT 8'h02
`define MCI_OP_MOTOR_HALT 8'h03
`define MCI_OP_MOVE_TO_POSITION 8'h04
`define MCI_OP_SET_AXIS_PARAM 8'h05
`define MCI_OP_GET_AXIS_PARAM 8'h06
`define MCI_OP_SET_GLOBAL_PARAM 8'h09
`define MCI_OP_GET_GLOBAL_PARAM 8'h0A
`define MCI_OP_SET_OUTPUT_PORT 8'h0E
`define MCI_OP_GET_INPUT_PORT 8'h0F
`define MCI_OP_ACCU_IMMEDIATE 8'h13
`define MCI_OP_COMPARE 8'h14
`define MCI_OP_JUMP_CONDITIONAL 8'h15
`define MCI_OP_JUMP_ALWAYS 8'h16
`define MCI_OP_WAIT 8'h1B
`define MCI_OP_PROGRAM_HALT 8'h1C
`define MCI_OP_STORE_COORD 8'h1E
`define MCI_OP_GET_COORD 8'h1F
`define MCI_OP_CAPTURE_COORD 8'h20
`define MCI_OP_ACCU_IMMEDIATE_A_ACCU_X 8'h21
`define MCI_OP_ACCU_TO_AXIS 8'h22
`define MCI_OP_ACCU_TO_GLOBAL 8'h23
`define MCI_OP_ACCU_TO_COORD 8'h27
`define MCI_OP_ACCU_IMMEDIATE_A_VAR_VAR 8'h28
`define MCI_OP_ACCU_IMMEDIATE_A_VAR_ACCU 8'h29
`define MCI_OP_ACCU_IMMEDIATE_A_ACCU_VAR 8'h2A
`define MCI_OP_ACCU_IMMEDIATE_A_VAR_X 8'h2B
`define MCI_OP_ACCU_IMMEDIATE_A_X_VAR 8'h2C
`define MCI_OP_ACCU_IMMEDIATE_A_VAR_IMM 8'h2D
`define MCI_OP_RESTART 8'h30
`define MCI_OP_DEC_BRANCH_NZ 8'h31
`define MCI_OP_ROTATE_LEFT_ACCU 8'h32
`define MCI_OP_ROTATE_RIGHT_ACCU 8'h33
`define MCI_OP_SET_INDEXED_VAR 8'h37
`define MCI_OP_GET_INDEXED_VAR 8'h38
`define MCI_OP_ACCU_TO_INDEXED 8'h39

// ----------------------------------------
// Arithmetic types
// ----------------------------------------
`define MCI_ALU_ADD 4'h0
`define MCI_ALU_SUB 4'h1
`define MCI_ALU_MUL 4'h2
`define MCI_ALU_AND 4'h5
`define MCI_ALU_OR 4'h6
`define MCI_ALU_XOR 4'h7
`define MCI_ALU_NOT 4'h8
`define MCI_ALU_LOAD 4'h9
`define MCI_ALU_TO_X 4'h0 // On accu_immediate_a_accu_with_x type 4'h0 is add; load-X uses type 4'hA.
`define MCI_ALU_LOAD_X 4'hA

// ----------------------------------------
// Status codes and condition codes
// ----------------------------------------
`define MCI_STATUS_OK 8'h64
`define MCI_STATUS_INVALID 8'h02
`define MCI_COND_ZERO 4'h0
`define MCI_COND_NONZERO 4'h1
`define MCI_COND_EQ 4'h2
`define MCI_COND_NE 4'h3
`define MCI_COND_GT 4'h4
`define MCI_COND_GE 4'h5
`define MCI_COND_LT 4'h6
`define MCI_COND_LE 4'h7

`endif

// ==== hdl/mci_alu.v ====
`timescale 1ns/100ps
`include "mci_defs.vh"

module mci_alu #(
  parameter WIDTH = 32
) (
  // Operands
  input wire [3:0] opType,
  input wire [WIDTH-1:0] opA,
  input wire [WIDTH-1:0] opB,
  // Result
  output reg [WIDTH-1:0] result
);

  reg [2*WIDTH-1:0] product;

  always @* begin
    product = opA * opB;
    case (opType)
      `MCI_ALU_ADD: result = opA + opB;
      `MCI_ALU_SUB: result = opA - opB;
      `MCI_ALU_MUL: result = product[WIDTH-1:0];
      `MCI_ALU_AND: result = opA & opB;
      `MCI_ALU_OR: result = opA | opB;
      `MCI_ALU_XOR: result = opA ^ opB;
      `MCI_ALU_NOT: result = ~opB;
      `MCI_ALU_LOAD: result = opB;
      default: result = opA;
    endcase
  end

endmodule // mci_alu

// ==== hdl/mci_interpreter.v ====
`timescale 1ns/100ps
`include "mci_defs.vh"

module mci_interpreter #(
  parameter WIDTH = 32,
  parameter ADDR_W = 8,
  parameter VAR_W = 6,
  parameter COORD_W = 4,
  parameter IO_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host command
  input wire hostValid,
  input wire [7:0] hostOpcode,
  input wire [7:0] hostType,
  input wire [7:0] hostMotor,
  input wire [WIDTH-1:0] hostValue,
  output reg hostReady_q,
  output reg replyValid_q,
  output reg [7:0] replyStatus_q,
  output reg [WIDTH-1:0] replyValue_q,
  // Program memory
  input wire runEnable,
  output reg [ADDR_W-1:0] progAddr_q,
  input wire [7:0] progOpcode,
  input wire [7:0] progType,
  input wire [7:0] progMotor,
  input wire [WIDTH-1:0] progValue,
  output reg progRunning_q,
  // Motion and parameter side
  output reg motionValid_q,
  output reg [7:0] motionOpcode_q,
  output reg [7:0] motionType_q,
  output reg [7:0] motionMotor_q,
  output reg [WIDTH-1:0] motionValue_q,
  output reg paramWrite_q,
  output reg paramGlobal_q,
  output reg [7:0] paramIndex_q,
  output reg [7:0] paramBank_q,
  output reg [WIDTH-1:0] paramWdata_q,
  input wire [WIDTH-1:0] axisParamRdata,
  input wire [WIDTH-1:0] globalParamRdata,
  input wire [WIDTH-1:0] coordRdata,
  input wire waitEvent,
  // I/O ports
  output reg [IO_W-1:0] outPort_q,
  input wire [IO_W-1:0] inPort,
  // Calculation state
  output reg [WIDTH-1:0] accu_q,
  output reg [WIDTH-1:0] xReg_q
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [WIDTH-1:0] userVar [0:(1<<VAR_W)-1];
  reg [WIDTH-1:0] coord [0:(1<<COORD_W)-1];
  reg [VAR_W-1:0] varIndex_q;
  reg [IO_W-1:0] inSync1_q;
  reg [IO_W-1:0] inSync2_q;
  reg flagZero_q;
  reg flagGreater_q;
  reg flagLess_q;
  reg waiting_q;

  // ----------------------------------------
  // Command source selection
  // ----------------------------------------
  // Host commands take priority; the program stalls for that cycle.
  wire hostTake = hostValid & hostReady_q;
  wire progTake = progRunning_q & runEnable & ~hostTake & ~waiting_q;
  wire [7:0] opc = hostTake ? hostOpcode : progOpcode;
  wire [7:0] typ = hostTake ? hostType : progType;
  wire [7:0] mot = hostTake ? hostMotor : progMotor;
  wire [WIDTH-1:0] val = hostTake ? hostValue : progValue;
  wire active = hostTake | progTake;

  wire [VAR_W-1:0] varA = typ[VAR_W-1:0];
  wire [VAR_W-1:0] varB = mot[VAR_W-1:0];
  wire [VAR_W-1:0] varV = val[VAR_W-1:0];
  wire [COORD_W-1:0] coordSel = typ[COORD_W-1:0];
  wire [WIDTH-1:0] decVar = userVar[varA] - {{(WIDTH-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // Operand selection for the shared ALU
  // ----------------------------------------
  reg [WIDTH-1:0] aluA;
  reg [WIDTH-1:0] aluB;
  reg [3:0] aluType;
  wire [WIDTH-1:0] aluOut;

  always @* begin
    aluA = accu_q;
    aluB = val;
    aluType = typ[3:0];
    case (opc)
      `MCI_OP_ACCU_IMMEDIATE_A_ACCU_X: aluB = xReg_q;
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_VAR: begin
        aluA = userVar[varB];
        aluB = userVar[varV];
      end
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_ACCU: begin
        aluA = userVar[varB];
        aluB = accu_q;
      end
      `MCI_OP_ACCU_IMMEDIATE_A_ACCU_VAR: begin
        aluA = accu_q;
        aluB = userVar[varB];
      end
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_X: begin
        aluA = userVar[varB];
        aluB = xReg_q;
      end
      `MCI_OP_ACCU_IMMEDIATE_A_X_VAR: begin
        aluA = xReg_q;
        aluB = userVar[varB];
      end
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_IMM: aluA = userVar[varB];
      default: aluA = accu_q;
    endcase
  end

  mci_alu #(
    .WIDTH(WIDTH)
  ) uAlu (
    .opType(aluType),
    .opA(aluA),
    .opB(aluB),
    .result(aluOut)
  );

  // ----------------------------------------
  // Read value for value-reading commands
  // ----------------------------------------
  reg [WIDTH-1:0] readVal;
  reg isRead;

  always @* begin
    readVal = {WIDTH{1'b0}};
    isRead = 1'b0;
    case (opc)
      `MCI_OP_GET_AXIS_PARAM: begin
        readVal = axisParamRdata;
        isRead = 1'b1;
      end
      `MCI_OP_GET_GLOBAL_PARAM: begin
        readVal = globalParamRdata;
        isRead = 1'b1;
      end
      `MCI_OP_GET_INPUT_PORT: begin
        readVal = {{(WIDTH-1){1'b0}}, inSync2_q[typ[2:0]]};
        isRead = 1'b1;
      end
      `MCI_OP_GET_COORD: begin
        readVal = coord[coordSel];
        isRead = 1'b1;
      end
      `MCI_OP_GET_INDEXED_VAR: begin
        readVal = userVar[varIndex_q];
        isRead = 1'b1;
      end
      default: isRead = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Opcode validity
  // ----------------------------------------
  reg known;

  always @* begin
    case (opc)
      `MCI_OP_ROTATE_RIGHT, `MCI_OP_ROTATE_LEFT, `MCI_OP_MOTOR_HALT, `MCI_OP_MOVE_TO_POSITION,
      `MCI_OP_SET_AXIS_PARAM, `MCI_OP_GET_AXIS_PARAM, `MCI_OP_SET_GLOBAL_PARAM, `MCI_OP_GET_GLOBAL_PARAM,
      `MCI_OP_SET_OUTPUT_PORT, `MCI_OP_GET_INPUT_PORT, `MCI_OP_ACCU_IMMEDIATE, `MCI_OP_COMPARE,
      `MCI_OP_JUMP_CONDITIONAL, `MCI_OP_JUMP_ALWAYS, `MCI_OP_WAIT, `MCI_OP_PROGRAM_HALT,
      `MCI_OP_STORE_COORD, `MCI_OP_GET_COORD, `MCI_OP_CAPTURE_COORD, `MCI_OP_ACCU_IMMEDIATE_A_ACCU_X,
      `MCI_OP_ACCU_TO_AXIS, `MCI_OP_ACCU_TO_GLOBAL, `MCI_OP_ACCU_TO_COORD, `MCI_OP_ACCU_IMMEDIATE_A_VAR_VAR,
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_ACCU, `MCI_OP_ACCU_IMMEDIATE_A_ACCU_VAR, `MCI_OP_ACCU_IMMEDIATE_A_VAR_X, `MCI_OP_ACCU_IMMEDIATE_A_X_VAR,
      `MCI_OP_ACCU_IMMEDIATE_A_VAR_IMM, `MCI_OP_RESTART, `MCI_OP_DEC_BRANCH_NZ, `MCI_OP_ROTATE_LEFT_ACCU,
      `MCI_OP_ROTATE_RIGHT_ACCU, `MCI_OP_SET_INDEXED_VAR, `MCI_OP_GET_INDEXED_VAR,
      `MCI_OP_ACCU_TO_INDEXED: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  reg condMet;

  always @* begin
    case (typ[3:0])
      `MCI_COND_ZERO: condMet = flagZero_q;
      `MCI_COND_NONZERO: condMet = ~flagZero_q;
      `MCI_COND_EQ: condMet = flagZero_q;
      `MCI_COND_NE: condMet = ~flagZero_q;
      `MCI_COND_GT: condMet = flagGreater_q;
      `MCI_COND_GE: condMet = flagGreater_q | flagZero_q;
      `MCI_COND_LT: condMet = flagLess_q;
      `MCI_COND_LE: condMet = flagLess_q | flagZero_q;
      default: condMet = 1'b0;
    endcase
  end

  wire [ADDR_W-1:0] nextAddr = progAddr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] jumpAddr = val[ADDR_W-1:0];
  wire signed [WIDTH-1:0] accuS = accu_q;
  wire signed [WIDTH-1:0] valS = val;

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  always @(posedge clk) begin
    inSync1_q <= inPort;
    inSync2_q <= inSync1_q;
    motionValid_q <= 1'b0;
    paramWrite_q <= 1'b0;
    replyValid_q <= 1'b0;
    if (rst) begin
      hostReady_q <= 1'b0;
      replyStatus_q <= 8'h00;
      replyValue_q <= {WIDTH{1'b0}};
      progAddr_q <= {ADDR_W{1'b0}};
      progRunning_q <= 1'b0;
      motionOpcode_q <= 8'h00;
      motionType_q <= 8'h00;
      motionMotor_q <= 8'h00;
      motionValue_q <= {WIDTH{1'b0}};
      paramGlobal_q <= 1'b0;
      paramIndex_q <= 8'h00;
      paramBank_q <= 8'h00;
      paramWdata_q <= {WIDTH{1'b0}};
      outPort_q <= {IO_W{1'b0}};
      accu_q <= {WIDTH{1'b0}};
      xReg_q <= {WIDTH{1'b0}};
      varIndex_q <= {VAR_W{1'b0}};
      flagZero_q <= 1'b0;
      flagGreater_q <= 1'b0;
      flagLess_q <= 1'b0;
      waiting_q <= 1'b0;
    end else begin
      hostReady_q <= 1'b1;
      if (waiting_q && waitEvent) begin
        waiting_q <= 1'b0;
      end
      if (!progRunning_q && runEnable) begin
        progRunning_q <= 1'b1;
      end
      if (active) begin
        if (progTake) begin
          progAddr_q <= nextAddr;
        end
        if (hostTake) begin
          replyValid_q <= 1'b1;
          replyStatus_q <= known ? `MCI_STATUS_OK : `MCI_STATUS_INVALID;
          replyValue_q <= readVal;
        end
        if (isRead && progTake) begin
          accu_q <= readVal;
        end
        case (opc)
          `MCI_OP_ROTATE_RIGHT, `MCI_OP_ROTATE_LEFT, `MCI_OP_MOTOR_HALT, `MCI_OP_MOVE_TO_POSITION,
          `MCI_OP_CAPTURE_COORD: begin
            motionValid_q <= 1'b1;
            motionOpcode_q <= opc;
            motionType_q <= typ;
            motionMotor_q <= mot;
            motionValue_q <= val;
          end
          `MCI_OP_ROTATE_LEFT_ACCU, `MCI_OP_ROTATE_RIGHT_ACCU: begin
            motionValid_q <= 1'b1;
            motionOpcode_q <= (opc == `MCI_OP_ROTATE_LEFT_ACCU) ? `MCI_OP_ROTATE_LEFT : `MCI_OP_ROTATE_RIGHT;
            motionType_q <= typ;
            motionMotor_q <= mot;
            motionValue_q <= accu_q;
          end
          `MCI_OP_SET_AXIS_PARAM, `MCI_OP_SET_GLOBAL_PARAM, `MCI_OP_ACCU_TO_AXIS, `MCI_OP_ACCU_TO_GLOBAL: begin
            paramWrite_q <= 1'b1;
            paramGlobal_q <= (opc == `MCI_OP_SET_GLOBAL_PARAM) || (opc == `MCI_OP_ACCU_TO_GLOBAL);
            paramIndex_q <= typ;
            paramBank_q <= mot;
            paramWdata_q <= ((opc == `MCI_OP_ACCU_TO_AXIS) || (opc == `MCI_OP_ACCU_TO_GLOBAL)) ? accu_q : val;
          end
          `MCI_OP_SET_OUTPUT_PORT: outPort_q[typ[2:0]] <= val[0];
          `MCI_OP_ACCU_IMMEDIATE: accu_q <= aluOut;
          `MCI_OP_ACCU_IMMEDIATE_A_ACCU_X: begin
            if (typ[3:0] == `MCI_ALU_LOAD_X) begin
              xReg_q <= accu_q;
            end else begin
              accu_q <= aluOut;
            end
          end
          `MCI_OP_ACCU_IMMEDIATE_A_VAR_ACCU, `MCI_OP_ACCU_IMMEDIATE_A_ACCU_VAR, `MCI_OP_ACCU_IMMEDIATE_A_VAR_X, `MCI_OP_ACCU_IMMEDIATE_A_X_VAR:
            accu_q <= aluOut;
          `MCI_OP_COMPARE: begin
            flagZero_q <= (accu_q == val);
            flagGreater_q <= (accuS > valS);
            flagLess_q <= (accuS < valS);
          end
          `MCI_OP_JUMP_ALWAYS: if (progTake) progAddr_q <= jumpAddr;
          `MCI_OP_JUMP_CONDITIONAL: if (progTake && condMet) progAddr_q <= jumpAddr;
          `MCI_OP_WAIT: if (progTake) waiting_q <= 1'b1;
          `MCI_OP_PROGRAM_HALT: if (progTake) progRunning_q <= 1'b0;
          `MCI_OP_RESTART: begin
            progAddr_q <= jumpAddr;
            progRunning_q <= 1'b1;
            waiting_q <= 1'b0;
          end
          `MCI_OP_DEC_BRANCH_NZ: if (progTake && decVar != {WIDTH{1'b0}}) progAddr_q <= jumpAddr;
          `MCI_OP_SET_INDEXED_VAR: varIndex_q <= varV;
          default: varIndex_q <= varIndex_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Variable and coordinate arrays (not reset)
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && active) begin
      case (opc)
        `MCI_OP_STORE_COORD: coord[coordSel] <= val;
        `MCI_OP_ACCU_TO_COORD: coord[coordSel] <= accu_q;
        `MCI_OP_ACCU_IMMEDIATE_A_VAR_VAR, `MCI_OP_ACCU_IMMEDIATE_A_VAR_IMM: userVar[varB] <= aluOut;
        `MCI_OP_DEC_BRANCH_NZ: if (progTake) userVar[varA] <= decVar;
        `MCI_OP_ACCU_TO_INDEXED: userVar[varIndex_q] <= accu_q;
        default: ;
      endcase
    end
  end

endmodule // mci_interpreter

// ==== testbench/mci_host_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// Host controller
// ----------------------------------------
module mci_host_model #(
  parameter WIDTH = 32
) (
  // Command handshake
  input wire clk,
  input wire hostReady_q,
  output logic hostValid,
  output logic [7:0] hostOpcode,
  output logic [7:0] hostType,
  output logic [7:0] hostMotor,
  output logic [WIDTH-1:0] hostValue
);
  initial begin
    hostValid = 1'b0;
    {hostOpcode, hostType, hostMotor, hostValue} = '0;
  end

  // Any opcode is offered until hostReady_q is seen, at most 100 cycles; fields idle at the inverse of the last command.
  task automatic send(input logic [7:0] op, ty, mo, input logic [WIDTH-1:0] va);
    int n;
    @(negedge clk);
    hostValid <= 1'b1;
    {hostOpcode, hostType, hostMotor, hostValue} <= {op, ty, mo, va};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hostReady_q !== 1'b1 && n < 100);
    @(negedge clk);
    hostValid <= 1'b0;
    {hostOpcode, hostType, hostMotor, hostValue} <= ~{op, ty, mo, va};
  endtask
endmodule // mci_host_model

// ==== testbench/mci_interpreter_assertions.sv ====
`timescale 1ns/100ps
`include "mci_defs.vh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module mci_interpreter_assertions #(
  parameter WIDTH = 32
) (
  // Clock, reset and host side
  input wire clk,
  input wire rst,
  input wire hostValid,
  input wire [7:0] hostOpcode,
  input wire [7:0] hostType,
  input wire hostReady_q,
  input wire replyValid_q,
  input wire [7:0] replyStatus_q,
  input wire [WIDTH-1:0] replyValue_q,
  // Program, motion, parameters and state
  input wire runEnable,
  input wire [7:0] progOpcode,
  input wire progRunning_q,
  input wire motionValid_q,
  input wire [7:0] motionOpcode_q,
  input wire [WIDTH-1:0] motionValue_q,
  input wire paramWrite_q,
  input wire paramGlobal_q,
  input wire [WIDTH-1:0] paramWdata_q,
  input wire [WIDTH-1:0] axisParamRdata,
  input wire [WIDTH-1:0] globalParamRdata,
  input wire [WIDTH-1:0] accu_q,
  input wire [WIDTH-1:0] xReg_q
);
  wire take = hostValid && hostReady_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ok;
    take && hostOpcode == 8'h06 |=> replyValid_q && replyStatus_q == `MCI_STATUS_OK;
  endproperty
  a_ok: assert property (p_ok) else $error("status not ok");
  property p_bad;
    take && (hostOpcode == 8'h1D || hostOpcode == 8'h2F || (hostOpcode >= 8'h34 && hostOpcode <= 8'h36))
      |=> replyStatus_q == `MCI_STATUS_INVALID && $stable(accu_q) && $stable(xReg_q) && !motionValid_q;
  endproperty
  a_bad: assert property (p_bad) else $error("invalid opcode acted");
  property p_axis;
    take && hostOpcode == 8'h06 |=> replyValue_q == $past(axisParamRdata) && $stable(accu_q);
  endproperty
  a_axis: assert property (p_axis) else $error("host read wrong");
  property p_glob;
    take && hostOpcode == 8'h0A |=> replyValue_q == $past(globalParamRdata);
  endproperty
  a_glob: assert property (p_glob) else $error("global read wrong");
  property p_toaxis;
    take && hostOpcode == 8'h22 |=> paramWrite_q && !paramGlobal_q && paramWdata_q == $past(accu_q);
  endproperty
  a_toaxis: assert property (p_toaxis) else $error("axis copy wrong");
  property p_toglob;
    take && hostOpcode == 8'h23 |=> paramWrite_q && paramGlobal_q && paramWdata_q == $past(accu_q);
  endproperty
  a_toglob: assert property (p_toglob) else $error("global copy wrong");
  property p_loadx;
    take && hostOpcode == 8'h21 && hostType == 8'h0A |=> xReg_q == $past(accu_q);
  endproperty
  a_loadx: assert property (p_loadx) else $error("x load wrong");
  property p_rot;
    take && hostOpcode == 8'h32 |=> motionValid_q && motionOpcode_q == 8'h02 && motionValue_q == $past(accu_q);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");
  property p_halt;
    progRunning_q && runEnable && !take && progOpcode == 8'h1C |=> !progRunning_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  c_bad: cover property (take && hostOpcode == 8'h1D);
  c_halt: cover property (progRunning_q ##1 !progRunning_q);
  c_rot: cover property (motionValid_q);
endmodule // mci_interpreter_assertions

bind mci_interpreter mci_interpreter_assertions #(.WIDTH(WIDTH)) u_chk (
  .clk(clk), .rst(rst), .hostValid(hostValid), .hostOpcode(hostOpcode), .hostType(hostType),
  .hostReady_q(hostReady_q), .replyValid_q(replyValid_q), .replyStatus_q(replyStatus_q),
  .replyValue_q(replyValue_q), .runEnable(runEnable), .progOpcode(progOpcode), .progRunning_q(progRunning_q),
  .motionValid_q(motionValid_q), .motionOpcode_q(motionOpcode_q), .motionValue_q(motionValue_q),
  .paramWrite_q(paramWrite_q), .paramGlobal_q(paramGlobal_q), .paramWdata_q(paramWdata_q),
  .axisParamRdata(axisParamRdata), .globalParamRdata(globalParamRdata), .accu_q(accu_q), .xReg_q(xReg_q));

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
  typedef struct packed {logic [7:0] st; logic [31:0] v, a, x;} mci_note_t;
  logic clk, rst, runEnable, waitEvent, hostValid, hostReady_q, replyValid_q;
  logic progRunning_q, motionValid_q, paramWrite_q, paramGlobal_q;
  logic [7:0] hostOpcode, hostType, hostMotor, replyStatus_q, progAddr_q, motionOpcode_q, inPort, outPort_q;
  logic [7:0] badOp [5] = '{8'h1D, 8'h2F, 8'h34, 8'h35, 8'h36};
  logic [31:0] hostValue, replyValue_q, motionValue_q, paramWdata_q, accu_q, xReg_q;
  logic [31:0] axisD, globD, coordD, expA, expX, ra, rb, rc;
  logic [55:0] prog [0:255];
  wire [55:0] ins = prog[progAddr_q];
  mci_note_t nq[$], n;
  logic [39:0] mq[$];
  logic [32:0] pq[$];
  int err_total = 0, comparisons = 0, cyc = 0, seed, i;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  mci_host_model host (.clk, .hostReady_q, .hostValid, .hostOpcode, .hostType, .hostMotor, .hostValue);

  mci_interpreter dut (
    .clk, .rst, .hostValid, .hostOpcode, .hostType, .hostMotor, .hostValue, .hostReady_q,
    .replyValid_q, .replyStatus_q, .replyValue_q, .runEnable, .progAddr_q,
    .progOpcode(ins[55:48]), .progType(ins[47:40]), .progMotor(ins[39:32]), .progValue(ins[31:0]),
    .progRunning_q, .motionValid_q, .motionOpcode_q, .motionType_q(), .motionMotor_q(), .motionValue_q,
    .paramWrite_q, .paramGlobal_q, .paramIndex_q(), .paramBank_q(), .paramWdata_q,
    .axisParamRdata(axisD), .globalParamRdata(globD), .coordRdata(coordD), .waitEvent,
    .outPort_q, .inPort, .accu_q, .xReg_q);

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic final_report;
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, ty, mo, input logic [31:0] va, rv, input logic [7:0] st = 8'h64);
    nq.push_back({st, rv, expA, expX});
    host.send(op, ty, mo, va);
  endtask

  always @(negedge clk) begin
    if (replyValid_q === 1'b1) begin
      n = nq.size() ? nq.pop_front() : {8'hEE, 96'h0};
      chk(replyStatus_q, n.st);
      chk(replyValue_q, n.v);
      chk(accu_q, n.a);
      chk(xReg_q, n.x);
    end
    if (motionValid_q === 1'b1)
      chk({motionOpcode_q, motionValue_q}, mq.size() ? mq.pop_front() : 40'hFFFFFFFFFF);
    if (paramWrite_q === 1'b1)
      chk({paramGlobal_q, paramWdata_q}, pq.size() ? pq.pop_front() : 33'h1FFFFFFFF);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    seed = 57;
    rst = 1'b1;
    runEnable = 1'b0;
    waitEvent = 1'b0;
    inPort = $random(seed);
    axisD = $random(seed);
    globD = $random(seed);
    coordD = $random(seed);
    {ra, rb, rc} = {$random(seed), $random(seed), $random(seed)};
    {expA, expX} = 64'h0;
    for (i = 0; i < 256; i++)
      prog[i] = {8'h13, 8'h09, 8'h00, 32'hBAD};
    prog[0] = {8'h2D, 8'h09, 8'h03, 32'h3};
    prog[1] = {8'h06, 8'h00, 8'h00, 32'h0};
    prog[2] = {8'h31, 8'h03, 8'h00, 32'h2};
    prog[3] = {8'h1B, 8'h00, 8'h00, 32'h0};
    prog[4] = {8'h14, 8'h00, 8'h00, axisD};
    prog[5] = {8'h15, 8'h02, 8'h00, 32'h7};
    prog[7] = {8'h16, 8'h00, 8'h00, 32'h9};
    prog[9] = {8'h30, 8'h00, 8'h00, 32'hB};
    prog[11] = {8'h1C, 48'h0};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    expA = ra;
    cmd(8'h13, 8'h09, 8'h00, ra, 0);
    expX = expA;
    cmd(8'h21, 8'h0A, 8'h00, 0, 0);
    expA = rb;
    cmd(8'h13, 8'h09, 8'h00, rb, 0);
    expA = rb - ra;
    cmd(8'h21, 8'h01, 8'h00, 0, 0);
    mq.push_back({8'h02, expA});
    cmd(8'h32, 8'h00, 8'h00, 0, 0);
    mq.push_back({8'h01, expA});
    cmd(8'h33, 8'h00, 8'h00, 0, 0);
    pq.push_back({1'b0, expA});
    cmd(8'h22, 8'h04, 8'h00, 0, 0);
    pq.push_back({1'b1, expA});
    cmd(8'h23, 8'h04, 8'h00, 0, 0);
    cmd(8'h27, 8'h02, 8'h00, 0, 0);
    cmd(8'h1F, 8'h02, 8'h00, 0, expA);
    cmd(8'h37, 8'h00, 8'h00, 7, 0);
    cmd(8'h39, 8'h00, 8'h00, 0, 0);
    cmd(8'h38, 8'h00, 8'h00, 0, expA);
    cmd(8'h2D, 8'h09, 8'h07, rc, 0);
    cmd(8'h38, 8'h00, 8'h00, 0, rc);
    expA = expA - rc;
    cmd(8'h2A, 8'h01, 8'h07, 0, 0);
    expA = rc - expA;
    cmd(8'h29, 8'h01, 8'h07, 0, 0);
    expA = expX - rc;
    cmd(8'h2C, 8'h01, 8'h07, 0, 0);
    expA = rc - expX;
    cmd(8'h2B, 8'h01, 8'h07, 0, 0);
    cmd(8'h28, 8'h00, 8'h07, 7, 0);
    cmd(8'h38, 8'h00, 8'h00, 0, rc + rc);
    cmd(8'h06, 8'h00, 8'h00, 0, axisD);
    cmd(8'h0A, 8'h00, 8'h00, 0, globD);
    foreach (badOp[k])
      cmd(badOp[k], 8'h00, 8'h00, 0, 0, 8'h02);
    cmd(8'h0E, 8'h03, 8'h00, 1, 0);
    chk(outPort_q, 8'h08);
    cmd(8'h0F, 8'h05, 8'h00, 0, inPort[5]);
    expA = axisD;
    runEnable = 1'b1;
    repeat (30) @(negedge clk);
    chk(progRunning_q, 1);
    chk(progAddr_q, 8'h04);
    cmd(8'h06, 8'h00, 8'h00, 0, axisD);
    waitEvent = 1'b1;
    for (i = 0; i < 50 && progRunning_q !== 1'b0; i++)
      @(negedge clk);
    runEnable = 1'b0;
    waitEvent = 1'b0;
    chk(progRunning_q, 0);
    chk(accu_q, axisD);
    cmd(8'h37, 8'h00, 8'h00, 3, 0);
    cmd(8'h38, 8'h00, 8'h00, 0, 0);
    repeat (5) @(negedge clk);
    chk(nq.size() + mq.size() + pq.size(), 0);
    final_report();
  end
endmodule // tb_top
